// ==== rta_pkg.sv ====
// Package of constants, types and register map for remote trigger timestamp alignment.
package rta_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int TS_W      = 48;
	localparam int ADJ_W     = TS_W + 1;
	localparam int OFF_W     = 16;
	localparam int SRC_W     = 2;
	localparam int N_MASTERS = 4;
	localparam int MSG_W     = SRC_W + TS_W;
	localparam int BIT_CNT_W = 6;
	localparam int CNT_W     = 16;

	// ==========================================================================
	// Register offsets (byte addresses)
	// ==========================================================================
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_REM_TS     = 8'h04;
	localparam logic [7:0] OFF_REM_DIG    = 8'h08;
	localparam logic [7:0] OFF_LOC_DIG    = 8'h0c;
	localparam logic [7:0] OFF_WIN_LO     = 8'h10;
	localparam logic [7:0] OFF_WIN_HI     = 8'h14;
	localparam logic [7:0] OFF_STATUS     = 8'h18;
	localparam logic [7:0] OFF_COINC_TS_L = 8'h1c;
	localparam logic [7:0] OFF_COINC_TS_H = 8'h20;
	localparam logic [7:0] OFF_AUX_TS_L   = 8'h24;
	localparam logic [7:0] OFF_AUX_TS_H   = 8'h28;

	// ==========================================================================
	// Field positions and reset values
	// ==========================================================================
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_PROP_LSB  = 8;
	localparam int ST_ARMED_BIT   = 0;
	localparam int ST_STATE_LSB   = 4;
	localparam int ST_COUNT_LSB   = 16;
	localparam logic [OFF_W-1:0] OFF_RESET   = 16'h0000;
	localparam logic [N_MASTERS-1:0] PROP_RESET = 4'h0;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_PERIOD_NS   = 10;
	localparam int NIM_LATENCY_NS  = 120;
	localparam int NIM_LATENCY_CYC = (NIM_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NIM_SYNC_CYC    = 2;
	localparam int NIM_WAIT_CYC    = NIM_LATENCY_CYC - NIM_SYNC_CYC;
	localparam int NIM_CNT_W       = 4;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_CHECK = 3'b100
	} rta_coinc_state_e;

	typedef struct packed {
		logic [SRC_W-1:0] src;
		logic [TS_W-1:0]  ts;
	} rta_remote_msg_s;

	typedef struct packed {
		logic            valid;
		logic [TS_W-1:0] ts;
	} rta_trig_s;

endpackage : rta_pkg

// ==== rta_sync.sv ====
// Two flip-flop synchroniser for signals arriving from outside the clock domain.
`timescale 1ns/10ps
module rta_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import rta_pkg::*;

	logic [W-1:0] meta;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : rta_sync

// ==== rta_ts_adjust.sv ====
// Registered signed timestamp adjuster: timestamp plus one offset minus another.
`timescale 1ns/10ps
module rta_ts_adjust (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      ce,
	input  wire logic                      in_valid,
	input  wire logic [rta_pkg::TS_W-1:0]  ts_in,
	input  wire logic [rta_pkg::OFF_W-1:0] plus_off,
	input  wire logic [rta_pkg::OFF_W-1:0] minus_off,
	output logic                           out_valid,
	output logic signed [rta_pkg::ADJ_W-1:0] adjusted
);
	import rta_pkg::*;

	logic signed [ADJ_W-1:0] next_adjusted;

	always_comb begin
		next_adjusted = $signed({1'b0, ts_in})
			+ $signed({{(ADJ_W - OFF_W){1'b0}}, plus_off})
			- $signed({{(ADJ_W - OFF_W){1'b0}}, minus_off});
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid <= 1'b0;
			adjusted  <= '0;
		end else if (ce) begin
			out_valid <= in_valid;
			if (in_valid) begin
				adjusted <= next_adjusted;
			end
		end
	end

endmodule : rta_ts_adjust

// ==== rta_remote_trig_align.sv ====
// Remote trigger timestamp alignment, coincidence and auxiliary input timestamping.
`timescale 1ns/10ps
module rta_remote_trig_align (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic                          ce,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic                          hready,
	input  wire logic [31:0]                   hwdata,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire logic [rta_pkg::TS_W-1:0]      system_ts,
	input  wire logic                          local_sum_trigger_algorithm,
	input  wire logic                          link_clk,
	input  wire logic                          link_frame,
	input  wire logic                          link_data,
	input  wire logic                          nim_aux_in,
	output rta_pkg::rta_trig_s                 fwd_trig,
	output logic      [rta_pkg::SRC_W-1:0]     fwd_src,
	output rta_pkg::rta_trig_s                 coinc_trig,
	output rta_pkg::rta_trig_s                 aux_trig
);
	import rta_pkg::*;

	localparam int AUX_LAG = NIM_WAIT_CYC;

	// ==========================================================================
	// Register state
	// ==========================================================================
	logic                    coinc_enable;
	logic [N_MASTERS-1:0]    prop_mask;
	logic [OFF_W-1:0]        remote_timestamp_offset;
	logic [OFF_W-1:0]        remote_digitizer_offset;
	logic [OFF_W-1:0]        local_digitizer_offset;
	logic [OFF_W-1:0]        win_lo;
	logic [OFF_W-1:0]        win_hi;
	logic [CNT_W-1:0]        coinc_count;
	logic                    wr_pend;
	logic [7:0]              wr_addr;
	logic [31:0]             next_rdata;
	logic                    bus_req;

	// ==========================================================================
	// Datapath state
	// ==========================================================================
	logic [2:0]              link_s;
	logic                    lclk_prev;
	logic                    frame_prev;
	logic [MSG_W-1:0]        shreg;
	logic [BIT_CNT_W-1:0]    bit_cnt;
	logic                    msg_valid;
	rta_remote_msg_s         msg;
	logic                    rem_in_valid;
	logic [SRC_W-1:0]        rem_src;
	logic                    rem_out_valid;
	logic signed [ADJ_W-1:0] rem_adj;
	logic                    loc_prev;
	logic                    local_pulse;
	logic                    loc_out_valid;
	logic signed [ADJ_W-1:0] loc_adj;
	logic signed [ADJ_W-1:0] adjusted_remote_trigger_time;
	logic signed [ADJ_W-1:0] adjusted_local_trigger_time;
	logic                    rem_have;
	logic                    loc_have;
	logic                    armed;
	rta_coinc_state_e        state;
	logic signed [ADJ_W:0]   diff;
	logic                    in_window;
	logic                    ts_reached;
	logic                    aux_s;
	logic                    aux_prev;
	logic                    aux_det;
	logic [NIM_CNT_W-1:0]    aux_cnt;
	logic [TS_W-1:0]         msg_ts_q;

	function automatic logic signed [ADJ_W:0] sext_win(input logic [OFF_W-1:0] v);
		sext_win = $signed({{(ADJ_W + 1 - OFF_W){v[OFF_W-1]}}, v});
	endfunction : sext_win

	// ==========================================================================
	// AHB-Lite slave
	// ==========================================================================
	assign bus_req = hsel && htrans[1] && hready;

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			OFF_CTRL: begin
				next_rdata[CTRL_EN_BIT] = coinc_enable;
				next_rdata[CTRL_PROP_LSB +: N_MASTERS] = prop_mask;
			end
			OFF_REM_TS:     next_rdata[OFF_W-1:0] = remote_timestamp_offset;
			OFF_REM_DIG:    next_rdata[OFF_W-1:0] = remote_digitizer_offset;
			OFF_LOC_DIG:    next_rdata[OFF_W-1:0] = local_digitizer_offset;
			OFF_WIN_LO:     next_rdata[OFF_W-1:0] = win_lo;
			OFF_WIN_HI:     next_rdata[OFF_W-1:0] = win_hi;
			OFF_STATUS: begin
				next_rdata[ST_ARMED_BIT] = armed;
				next_rdata[ST_STATE_LSB +: 3] = state;
				next_rdata[ST_COUNT_LSB +: CNT_W] = coinc_count;
			end
			OFF_COINC_TS_L: next_rdata = coinc_trig.ts[31:0];
			OFF_COINC_TS_H: next_rdata[TS_W-33:0] = coinc_trig.ts[TS_W-1:32];
			OFF_AUX_TS_L:   next_rdata = aux_trig.ts[31:0];
			OFF_AUX_TS_H:   next_rdata[TS_W-33:0] = aux_trig.ts[TS_W-1:32];
			default:        next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= bus_req && hwrite;
			if (bus_req) begin
				wr_addr <= haddr[7:0];
			end
			if (bus_req && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coinc_enable            <= 1'b0;
			prop_mask               <= PROP_RESET;
			remote_timestamp_offset <= OFF_RESET;
			remote_digitizer_offset <= OFF_RESET;
			local_digitizer_offset  <= OFF_RESET;
			win_lo                  <= OFF_RESET;
			win_hi                  <= OFF_RESET;
		end else if (ce && wr_pend) begin
			unique case (wr_addr)
				OFF_CTRL: begin
					coinc_enable <= hwdata[CTRL_EN_BIT];
					prop_mask    <= hwdata[CTRL_PROP_LSB +: N_MASTERS];
				end
				OFF_REM_TS:  remote_timestamp_offset <= hwdata[OFF_W-1:0];
				OFF_REM_DIG: remote_digitizer_offset <= hwdata[OFF_W-1:0];
				OFF_LOC_DIG: local_digitizer_offset  <= hwdata[OFF_W-1:0];
				OFF_WIN_LO:  win_lo <= hwdata[OFF_W-1:0];
				OFF_WIN_HI:  win_hi <= hwdata[OFF_W-1:0];
				default: begin
				end
			endcase
		end
	end

	offset_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && wr_pend && wr_addr == OFF_REM_DIG |=>
		remote_digitizer_offset == $past(hwdata[OFF_W-1:0]))
		else $error("remote digitizer offset write lost");

	// ==========================================================================
	// Serial link receiver
	// ==========================================================================
	rta_sync #(.W(3)) u_link_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.d       ({link_clk, link_frame, link_data}),
		.q       (link_s)
	);

	assign msg = rta_remote_msg_s'(shreg);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lclk_prev  <= 1'b0;
			frame_prev <= 1'b0;
			shreg      <= '0;
			bit_cnt    <= '0;
			msg_valid  <= 1'b0;
		end else if (ce) begin
			lclk_prev  <= link_s[2];
			frame_prev <= link_s[1];
			msg_valid  <= frame_prev && !link_s[1] && bit_cnt == BIT_CNT_W'(MSG_W);
			if (!link_s[1]) begin
				bit_cnt <= '0;
			end else if (link_s[2] && !lclk_prev && bit_cnt != BIT_CNT_W'(MSG_W)) begin
				shreg   <= {shreg[MSG_W-2:0], link_s[0]};
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

	// ==========================================================================
	// Remote trigger adjustment and forwarding
	// ==========================================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rem_in_valid <= 1'b0;
			rem_src      <= '0;
			msg_ts_q     <= '0;
		end else if (ce) begin
			rem_in_valid <= msg_valid && prop_mask[msg.src];
			if (msg_valid) begin
				rem_src  <= msg.src;
				msg_ts_q <= msg.ts;
			end
		end
	end

	rta_ts_adjust u_rem_adjust (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.in_valid  (rem_in_valid),
		.ts_in     (msg_ts_q),
		.plus_off  (remote_timestamp_offset),
		.minus_off (remote_digitizer_offset),
		.out_valid (rem_out_valid),
		.adjusted  (rem_adj)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_trig <= '0;
			fwd_src  <= '0;
		end else if (ce) begin
			fwd_trig.valid <= rem_out_valid;
			if (rem_out_valid) begin
				fwd_trig.ts <= rem_adj[TS_W-1:0];
				fwd_src     <= rem_src;
			end
		end
	end

	prop_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && msg_valid && !prop_mask[msg.src] |=> !rem_in_valid)
		else $error("masked master was propagated");

	remote_adj_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && rem_in_valid |=> rem_out_valid && rem_adj == $signed({1'b0, $past(msg_ts_q)})
		+ $signed({33'h0, $past(remote_timestamp_offset)})
		- $signed({33'h0, $past(remote_digitizer_offset)}))
		else $error("remote timestamp adjustment wrong");

	forward_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && rem_in_valid |-> ##2 fwd_trig.valid && fwd_trig.ts == $past(msg_ts_q, 2)
		+ TS_W'($past(remote_timestamp_offset, 2)) - TS_W'($past(remote_digitizer_offset, 2)))
		else $error("adjusted trigger not forwarded");

	// ==========================================================================
	// Local trigger pulse and adjustment
	// ==========================================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loc_prev    <= 1'b0;
			local_pulse <= 1'b0;
		end else if (ce) begin
			loc_prev    <= local_sum_trigger_algorithm;
			local_pulse <= local_sum_trigger_algorithm && !loc_prev;
		end
	end

	rta_ts_adjust u_loc_adjust (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.in_valid  (local_pulse),
		.ts_in     (system_ts),
		.plus_off  (OFF_RESET),
		.minus_off (local_digitizer_offset),
		.out_valid (loc_out_valid),
		.adjusted  (loc_adj)
	);

	local_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && local_sum_trigger_algorithm && !loc_prev ##1 ce |=> loc_out_valid)
		else $error("local trigger did not reach coincidence");

	// ==========================================================================
	// Coincidence logic
	// ==========================================================================
	assign diff       = $signed({adjusted_local_trigger_time[ADJ_W-1], adjusted_local_trigger_time})
		- $signed({adjusted_remote_trigger_time[ADJ_W-1], adjusted_remote_trigger_time});
	assign in_window  = diff >= sext_win(win_lo) && diff <= sext_win(win_hi);
	assign ts_reached = $signed({1'b0, system_ts}) >= adjusted_remote_trigger_time;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adjusted_remote_trigger_time <= '0;
			adjusted_local_trigger_time  <= '0;
			rem_have <= 1'b0;
			loc_have <= 1'b0;
		end else if (ce) begin
			if (rem_out_valid) begin
				adjusted_remote_trigger_time <= rem_adj;
				rem_have <= 1'b1;
			end
			if (loc_out_valid) begin
				adjusted_local_trigger_time <= loc_adj;
				loc_have <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed <= 1'b0;
		end else if (ce) begin
			if (!coinc_enable) begin
				armed <= 1'b0;
			end else if (rem_have && loc_have && adjusted_remote_trigger_time > 0
				&& adjusted_local_trigger_time > 0) begin
				armed <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state       <= ST_IDLE;
			coinc_trig  <= '0;
			coinc_count <= '0;
		end else if (ce) begin
			coinc_trig.valid <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (rem_out_valid) begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!rem_out_valid && ts_reached) begin
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					state <= rem_out_valid ? ST_WAIT : ST_IDLE;
					if (coinc_enable && armed && loc_have && in_window) begin
						coinc_trig.valid <= 1'b1;
						coinc_trig.ts    <= system_ts;
						coinc_count      <= coinc_count + 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	wait_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state == ST_WAIT && ts_reached && !rem_out_valid |=> state == ST_CHECK)
		else $error("remote time reached but no window check");

	armed_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		coinc_trig.valid |-> $past(armed) && $past(coinc_enable))
		else $error("coincidence issued while disarmed");

	window_check_a: assert property (@(posedge hclk) disable iff (!hresetn)
		coinc_trig.valid |-> $past(in_window) && $past(state) == ST_CHECK)
		else $error("coincidence outside window");

	coinc_stamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		coinc_trig.valid |-> coinc_trig.ts == $past(system_ts))
		else $error("coincidence timestamp not raw internal time");

	// ==========================================================================
	// Auxiliary input timestamp
	// ==========================================================================
	rta_sync #(.W(1)) u_aux_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.d       (nim_aux_in),
		.q       (aux_s)
	);

	assign aux_det = aux_s && !aux_prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_prev <= 1'b0;
			aux_cnt  <= '0;
			aux_trig <= '0;
		end else if (ce) begin
			aux_prev       <= aux_s;
			aux_trig.valid <= 1'b0;
			if (aux_det) begin
				aux_cnt <= NIM_CNT_W'(NIM_WAIT_CYC - 1);
			end else if (aux_cnt != '0) begin
				aux_cnt <= aux_cnt - 1'b1;
				if (aux_cnt == NIM_CNT_W'(1)) begin
					aux_trig.valid <= 1'b1;
					aux_trig.ts    <= system_ts;
				end
			end
		end
	end

	aux_lag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		aux_det && ce ##1 ce [*8] |=> ##1 aux_trig.valid && aux_trig.ts == $past(system_ts))
		else $error("auxiliary timestamp latency wrong");

endmodule : rta_remote_trig_align

// ==== rta_remote_master.sv ====
// Behavioural model of the remote master trigger that sends serial trigger messages.
`timescale 1ns/10ps
module rta_remote_master (
	input  wire logic             go,
	input  wire rta_pkg::rta_remote_msg_s msg,
	input  wire logic [5:0]       nbits,
	output logic                  link_clk = 1'b0,
	output logic                  link_frame = 1'b0,
	output logic                  link_data = 1'b0,
	output logic                  busy = 1'b0
);
	import rta_pkg::*;
	// =====
	// Sender
	// =====
	// The clock runs only inside a frame, and the data line flips after it so stale bits never look valid.
	always @(posedge go) begin
		busy = 1'b1;
		link_frame = 1'b1;
		for (int i = 0; i < nbits; i++) begin
			link_data = msg[MSG_W-1-i];
			#40 link_clk = 1'b1;
			#80 link_clk = 1'b0;
			#40;
		end
		link_frame = 1'b0;
		link_data = ~link_data;
		#400 busy = 1'b0;
	end
endmodule : rta_remote_master

// ==== tb.sv ====
// Self-checking testbench for the remote trigger alignment block.
`timescale 1ns/10ps
module tb;
	import rta_pkg::*;
	// =====
	// Signals
	// =====
	logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic             loc = 1'b0, nim = 1'b0, go = 1'b0, hrdy, hresp, lclk, lfrm, ldat, busy;
	logic [1:0]       htrans = 2'b00;
	logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [TS_W-1:0]  sts = 48'd1000, t0;
	logic [5:0]       nb = 6'd50;
	logic [SRC_W-1:0] fsrc;
	rta_remote_msg_s  msg = '0;
	rta_trig_s        fwd, coi, aux;
	int               bad_count, comparisons, nf, nc, na, gap;

	rta_remote_trig_align u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hrdy),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .system_ts(sts),
		.local_sum_trigger_algorithm(loc), .link_clk(lclk), .link_frame(lfrm),
		.link_data(ldat), .nim_aux_in(nim), .fwd_trig(fwd), .fwd_src(fsrc),
		.coinc_trig(coi), .aux_trig(aux));

	rta_remote_master u_rem (.go(go), .msg(msg), .nbits(nb), .link_clk(lclk),
		.link_frame(lfrm), .link_data(ldat), .busy(busy));

	initial begin
		forever #5 hclk = ~hclk;
	end

	// =====
	// Running timestamp and pulse counters
	// =====
	always @(posedge hclk) begin
		sts <= sts + 48'h1;
		if (fwd.valid === 1'b1) nf++;
		if (aux.valid === 1'b1) na++;
		if (coi.valid === 1'b1) begin
			nc++;
			gap = int'(sts - coi.ts);
		end
	end

	// =====
	// Tasks
	// =====
	task chk(input string n, input logic [48:0] e, input logic [48:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	task tmo(input string n);
		bad_count++;
		$display("[FAIL] %s expected done seen timeout", n);
		finish_test();
	endtask : tmo

	task hs();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hrdy !== 1'b1 && i < 50);
		if (hrdy !== 1'b1) tmo("hready");
	endtask : hs

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		hs();
		htrans <= 2'b00;
		hwdata <= d;
		hs();
		q = hrdata;
	endtask : bus

	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(n, {17'h0, e}, {17'h0, q});
	endtask : rc

	task send(input logic [1:0] s, input logic [47:0] t, input logic [5:0] n);
		int i;
		msg <= {s, t};
		nb <= n;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (busy === 1'b1 && i < 2000);
		if (busy === 1'b1) tmo("link");
	endtask : send

	task til(input logic [47:0] t);
		int i;
		i = 0;
		while (sts < t && i < 3000) begin
			@(posedge hclk);
			i++;
		end
		if (sts < t) tmo("time");
	endtask : til

	// =====
	// Tests
	// =====
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc("ctrl", OFF_CTRL, 32'h0);
		rc("remts", OFF_REM_TS, 32'h0);
		rc("hole", 8'h40, 32'h0);
		chk("hresp", 49'h0, {48'h0, hresp});
		$display("test reset done");
		bus(OFF_REM_TS, 1'b1, 32'hffff_0100);
		rc("remts", OFF_REM_TS, 32'h0000_0100);
		bus(OFF_REM_DIG, 1'b1, 32'h0000_0010);
		rc("remdig", OFF_REM_DIG, 32'h0000_0010);
		bus(OFF_WIN_LO, 1'b1, 32'h0000_ff9c);
		bus(OFF_WIN_HI, 1'b1, 32'h0000_0064);
		bus(OFF_CTRL, 1'b1, 32'h0000_0201);
		rc("ctrl", OFF_CTRL, 32'h0000_0201);
		$display("test registers done");
		send(2'd1, 48'd100, 6'd50);
		chk("fwdts", {1'b0, 48'd340}, {1'b0, fwd.ts});
		chk("fwdsrc", 49'd1, {47'h0, fsrc});
		chk("fwdn", 49'd1, 49'(nf));
		send(2'd2, 48'd200, 6'd50);
		send(2'd1, 48'd300, 6'd49);
		chk("fwdn", 49'd1, 49'(nf));
		$display("test forward done");
		bus(OFF_REM_TS, 1'b1, 32'h0);
		send(2'd1, 48'd5, 6'd50);
		chk("negts", {1'b0, 48'hffff_ffff_fff5}, {1'b0, fwd.ts});
		chk("coin", 49'd0, 49'(nc));
		loc <= 1'b1;
		@(posedge hclk);
		loc <= 1'b0;
		repeat (4) @(posedge hclk);
		rc("armed", OFF_STATUS, 32'h0000_0010);
		bus(OFF_REM_TS, 1'b1, 32'h0000_0100);
		bus(OFF_LOC_DIG, 1'b1, 32'h0000_0030);
		rc("locdig", OFF_LOC_DIG, 32'h0000_0030);
		$display("test negative done");
		t0 = sts + 48'd1200;
		send(2'd1, t0 - 48'd240, 6'd50);
		til(t0 - 48'd50);
		loc <= 1'b1;
		@(posedge hclk);
		loc <= 1'b0;
		til(t0 + 48'd100);
		chk("coin", 49'd1, 49'(nc));
		chk("cgap", 49'd1, 49'(gap));
		chk("cts", 49'd1, 49'(coi.ts >= t0 && coi.ts <= t0 + 48'd2));
		rc("status", OFF_STATUS, 32'h0001_0011);
		rc("ctsl", OFF_COINC_TS_L, 32'(t0 + 48'd1));
		rc("ctsh", OFF_COINC_TS_H, 32'((t0 + 48'd1) >> 32));
		$display("test coincidence done");
		t0 = sts + 48'd1200;
		send(2'd1, t0 - 48'd240, 6'd50);
		loc <= 1'b1;
		@(posedge hclk);
		loc <= 1'b0;
		til(t0 + 48'd100);
		chk("coin", 49'd1, 49'(nc));
		$display("test window done");
		t0 = sts;
		nim <= 1'b1;
		til(t0 + 48'd40);
		nim <= 1'b0;
		chk("auxn", 49'd1, 49'(na));
		chk("auxlag", 49'd1, 49'(aux.ts >= t0 + 48'd12 && aux.ts <= t0 + 48'd16));
		rc("auxl", OFF_AUX_TS_L, 32'(t0 + 48'd12));
		rc("auxh", OFF_AUX_TS_H, 32'((t0 + 48'd12) >> 32));
		$display("test aux done");
		finish_test();
	end
endmodule : tb
